// file: hw/erl_map.vh
// constants for the eeprom register burst loader
// assumes inclusion by the erl byte reader and loader design files, not by the fifo
`ifndef ERL_MAP_VH
`define ERL_MAP_VH

// avalon register byte offsets
`define ERL_OFS_CMD       4'h0
`define ERL_OFS_HWCFG     4'h4
`define ERL_OFS_STRAP     4'h8
`define ERL_OFS_WRCNT     4'hc

// eeprom_command_reg fields
`define ERL_CMD_BUSY      31
`define ERL_CMD_OVF       10
`define ERL_CMD_RELOAD    0
// hardware_config_reg fields
`define ERL_HW_READY      27

// eeprom layout
`define ERL_VALID_BYTE    8'ha5
`define ERL_MAC_BYTES     4'h6
`define ERL_STRAP_BYTES   4'h4
`define ERL_DW_BYTES      4'h4

// address limits selected by the eeprom size strap
`define ERL_LIMIT_0       16'h007f
`define ERL_LIMIT_1       16'h07ff
`define ERL_LIMIT_2       16'h3fff
`define ERL_LIMIT_3       16'hffff

// fifo shape
`define ERL_FIFO_W        8
`define ERL_FIFO_D        8
`define ERL_FIFO_AW       3

`endif

// file: hw/erl_fifo.v
// synchronous fifo with valid/ready on both sides
// assumes a single clock and an active high asynchronous reset
`timescale 1ns/1ns
module erl_fifo #(
   parameter W  = 8,
   parameter D  = 8,
   parameter AW = 3
) (
   // clock and reset
   input  wire          clk,
   input  wire          reset,
   input  wire          clr,
   // fill side
   input  wire          inValid,
   output wire          inReady,
   input  wire [W-1:0]  inData,
   // drain side
   output wire          outValid,
   input  wire          outReady,
   output wire [W-1:0]  outData
);
   reg  [W-1:0]  mem [0:D-1];
   reg  [AW-1:0] wrPtr_reg;
   reg  [AW-1:0] rdPtr_reg;
   reg  [AW:0]   count_reg;
   wire          push;
   wire          pop;

   assign inReady  = (count_reg != D[AW:0]);
   assign outValid = (count_reg != {(AW+1){1'b0}});
   assign outData  = mem[rdPtr_reg];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always @(posedge clk) begin
      if (push) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         wrPtr_reg <= {AW{1'b0}};
         rdPtr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else if (clr) begin
         wrPtr_reg <= {AW{1'b0}};
         rdPtr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) wrPtr_reg <= (wrPtr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
         if (pop)  rdPtr_reg <= (rdPtr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
         if (push & ~pop) count_reg <= count_reg + 1'b1;
         else if (pop & ~push) count_reg <= count_reg - 1'b1;
      end
   end
endmodule // erl_fifo

// file: hw/erl_byte_reader.v
// sequential eeprom byte fetcher feeding the byte fifo
// assumes eeprom answers each held request with a one-cycle ack
`timescale 1ns/1ns
`include "erl_map.vh"
module erl_byte_reader (
   // clock and reset
   input  wire        clk,
   input  wire        reset,
   // control
   input  wire        start,
   input  wire        stop,
   input  wire [15:0] limit,
   output reg         ovf_reg,
   // eeprom byte port
   output reg         eeReq_reg,
   output reg  [15:0] eeAddr_reg,
   input  wire        eeAck,
   input  wire [7:0]  eeData,
   // byte stream
   output wire        outValid,
   input  wire        outReady,
   output wire [7:0]  outData
);
   reg run_reg;
   reg drop_reg;

   assign outValid = eeAck & eeReq_reg & run_reg & ~drop_reg;
   assign outData  = eeData;

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         run_reg    <= 1'b0;
         drop_reg   <= 1'b0;
         ovf_reg    <= 1'b0;
         eeReq_reg  <= 1'b0;
         eeAddr_reg <= 16'h0000;
      end else if (start) begin
         run_reg    <= 1'b1;
         ovf_reg    <= 1'b0;
         drop_reg   <= eeReq_reg & ~eeAck;
         eeReq_reg  <= eeReq_reg & ~eeAck;
         eeAddr_reg <= (eeReq_reg & ~eeAck) ? eeAddr_reg : 16'h0000;
      end else if (eeReq_reg) begin
         if (eeAck) begin
            eeReq_reg  <= 1'b0;
            drop_reg   <= 1'b0;
            eeAddr_reg <= drop_reg ? 16'h0000 : eeAddr_reg + 16'h0001;
            if (stop) run_reg <= 1'b0;
         end
      end else if (stop) begin
         run_reg <= 1'b0;
      end else if (run_reg && outReady) begin
         if (eeAddr_reg > limit || (eeAddr_reg == 16'h0000 && ovf_reg)) begin
            ovf_reg <= 1'b1;
            run_reg <= 1'b0;
         end else begin
            eeReq_reg <= 1'b1;
         end
      end
   end
endmodule // erl_byte_reader

// file: hw/erl_loader.v
// eeprom loader: validity flags, soft straps and register bursts
// assumes one 25 mhz clock; eeprom, busy flags and register port synchronous
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "erl_map.vh"

// Functional notes
// - reset, digital reset or reload set busy and drop ready until done.
// - byte 0 not A5h: push sampled straps to PHYs, finish, clear busy.
// - byte 7 is strap flag; bytes 8-11 applied only when it is A5h.
// - byte 12 is burst flag; bursts parsed only when it equals A5h.
// - invalid burst flag: finish, wait state, clear busy.
// - byte 13 counts bursts; exactly that many bursts processed.
// - burst header: first byte address bits 9:2, second byte dword count.
// - each dword is four bytes, most significant first, one 32-bit value.
// - byte register address is the dword address with two zero bits appended.
// - bursts reach only directly writable registers on the write port.
// - each write waits until switch Switch_port_busy and PHY management busy clear.
// - read beyond eeprom space stops loader and sets overflow flag; at size strap 3 (limit FFFFh) the reader wraps to address 0 instead, no flag.
// - address limit is the largest size of the strap-selected range.
// - after final burst enter wait state and clear busy.
// - straps sampled at reset release, then overridden by eeprom data.
// - after strap override, PHY and virtual PHY registers rewritten; also on reload.
module erl_loader (
   // clock and reset
   input  wire        clk,
   input  wire        reset,
   // avalon-mm slave
   input  wire [3:0]  avsAddress,
   input  wire        avsRead,
   input  wire        avsWrite,
   input  wire [31:0] avsWriteData,
   output reg  [31:0] avsReadData,
   output wire        avsWaitRequest,
   // reset sources and straps
   input  wire        digitalReset,
   input  wire [31:0] strapIn,
   input  wire [1:0]  eepromSizeStrap,
   // eeprom byte port
   output wire        eeReq,
   output wire [15:0] eeAddr,
   input  wire        eeAck,
   input  wire [7:0]  eeData,
   // busy flags of shared interfaces
   input  wire        switchPortBusy,
   input  wire        phyMgmtBusy,
   // direct register write port
   output reg         regWrEn,
   output reg  [9:0]  regWrAddr,
   output reg  [31:0] regWrData,
   // strap and phy synchronisation
   output reg  [31:0] strapValue,
   output reg         phyResync,
   // status
   output wire        loaderBusy,
   output wire        deviceReady
);
   localparam [11:0] S_START = 12'h001;
   localparam [11:0] S_CHECK = 12'h002;
   localparam [11:0] S_MAC   = 12'h004;
   localparam [11:0] S_SFLAG = 12'h008;
   localparam [11:0] S_STRAP = 12'h010;
   localparam [11:0] S_BFLAG = 12'h020;
   localparam [11:0] S_BCNT  = 12'h040;
   localparam [11:0] S_HADDR = 12'h080;
   localparam [11:0] S_HCNT  = 12'h100;
   localparam [11:0] S_DATA  = 12'h200;
   localparam [11:0] S_WRITE = 12'h400;
   localparam [11:0] S_WAIT  = 12'h800;

   reg  [11:0] state_reg;
   reg  [11:0] state_next;
   reg         busy_reg;
   reg         ovfFlag_reg;
   reg         strapValid_reg;
   reg         sampled_reg;
   reg  [31:0] strapSample_reg;
   reg  [3:0]  byteCnt_reg;
   reg  [7:0]  burstCnt_reg;
   reg  [7:0]  dwCnt_reg;
   reg  [7:0]  dwAddr_reg;
   reg  [31:0] assemble_reg;
   reg  [31:0] wrCount_reg;
   reg         ack_reg;
   reg  [15:0] limit;
   reg         restart;
   wire        reload;
   wire        busWr;
   wire        fifoInValid;
   wire        fifoInReady;
   wire [7:0]  fifoInData;
   wire        byteValid;
   wire [7:0]  byteData;
   wire        readerOvf;
   wire        needByte;
   wire        take;
   wire        isValid;
   wire        wrClear;

   assign loaderBusy     = busy_reg;
   assign deviceReady    = ~busy_reg;
   assign avsWaitRequest = (avsRead | avsWrite) & ~ack_reg;
   assign busWr          = avsWrite & ack_reg;
   assign reload         = busWr && avsAddress == `ERL_OFS_CMD
                           && avsWriteData[`ERL_CMD_RELOAD] && !busy_reg;
   assign needByte       = (state_reg & (S_CHECK | S_MAC | S_SFLAG | S_STRAP | S_BFLAG
                           | S_BCNT | S_HADDR | S_HCNT | S_DATA)) != 12'h000;
   assign take           = needByte & byteValid;
   assign isValid        = (byteData == `ERL_VALID_BYTE);
   assign wrClear        = ~switchPortBusy & ~phyMgmtBusy;

   // eeprom size strap picks the top of its size range
   always @* begin
      case (eepromSizeStrap)
         2'h0:    limit = `ERL_LIMIT_0;
         2'h1:    limit = `ERL_LIMIT_1;
         2'h2:    limit = `ERL_LIMIT_2;
         default: limit = `ERL_LIMIT_3;
      endcase
   end

   // restart on reset release, digital reset or reload
   always @* begin
      restart = digitalReset | reload | (state_reg == S_START && sampled_reg);
   end

   erl_byte_reader u_reader (
      .clk        (clk),
      .reset      (reset),
      .start      (restart),
      .stop       (state_reg == S_WAIT),
      .limit      (limit),
      .ovf_reg    (readerOvf),
      .eeReq_reg  (eeReq),
      .eeAddr_reg (eeAddr),
      .eeAck      (eeAck),
      .eeData     (eeData),
      .outValid   (fifoInValid),
      .outReady   (fifoInReady),
      .outData    (fifoInData)
   );

   erl_fifo #(
      .W  (`ERL_FIFO_W),
      .D  (`ERL_FIFO_D),
      .AW (`ERL_FIFO_AW)
   ) u_fifo (
      .clk      (clk),
      .reset    (reset),
      .clr      (restart),
      .inValid  (fifoInValid),
      .inReady  (fifoInReady),
      .inData   (fifoInData),
      .outValid (byteValid),
      .outReady (needByte),
      .outData  (byteData)
   );

   // byte parser
   always @* begin
      state_next = state_reg;
      case (state_reg)
         S_START: if (sampled_reg) state_next = S_CHECK;
         S_CHECK: if (take) state_next = isValid ? S_MAC : S_WAIT;
         S_MAC:   if (take && byteCnt_reg == `ERL_MAC_BYTES - 4'h1) state_next = S_SFLAG;
         S_SFLAG: if (take) state_next = S_STRAP;
         S_STRAP: if (take && byteCnt_reg == `ERL_STRAP_BYTES - 4'h1) state_next = S_BFLAG;
         S_BFLAG: if (take) state_next = isValid ? S_BCNT : S_WAIT;
         S_BCNT:  if (take) state_next = (byteData == 8'h00) ? S_WAIT : S_HADDR;
         S_HADDR: if (take) state_next = S_HCNT;
         S_HCNT: begin
            if (take) begin
               if (byteData != 8'h00) state_next = S_DATA;
               else if (burstCnt_reg == 8'h01) state_next = S_WAIT;
               else state_next = S_HADDR;
            end
         end
         S_DATA:  if (take && byteCnt_reg == `ERL_DW_BYTES - 4'h1) state_next = S_WRITE;
         S_WRITE: begin
            if (wrClear) begin
               if (dwCnt_reg != 8'h01) state_next = S_DATA;
               else if (burstCnt_reg != 8'h01) state_next = S_HADDR;
               else state_next = S_WAIT;
            end
         end
         S_WAIT:  state_next = S_WAIT;
         default: state_next = S_WAIT;
      endcase
      // a byte the reader cannot fetch ends the load
      if (needByte && !byteValid && readerOvf) state_next = S_WAIT;
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg       <= S_START;
         busy_reg        <= 1'b1;
         ovfFlag_reg     <= 1'b0;
         strapValid_reg  <= 1'b0;
         sampled_reg     <= 1'b0;
         strapSample_reg <= 32'h00000000;
         strapValue      <= 32'h00000000;
         byteCnt_reg     <= 4'h0;
         burstCnt_reg    <= 8'h00;
         dwCnt_reg       <= 8'h00;
         dwAddr_reg      <= 8'h00;
         assemble_reg    <= 32'h00000000;
         regWrEn         <= 1'b0;
         regWrAddr       <= 10'h000;
         regWrData       <= 32'h00000000;
         phyResync       <= 1'b0;
         wrCount_reg     <= 32'h00000000;
      end else begin
         regWrEn   <= 1'b0;
         phyResync <= 1'b0;
         // straps caught in the first cycle after reset release
         if (!sampled_reg) begin
            sampled_reg     <= 1'b1;
            strapSample_reg <= strapIn;
            strapValue      <= strapIn;
         end
         if (restart) begin
            state_reg      <= S_CHECK;
            busy_reg       <= 1'b1;
            byteCnt_reg    <= 4'h0;
            strapValid_reg <= 1'b0;
            strapValue     <= sampled_reg ? strapSample_reg : strapIn;
         end else begin
            state_reg <= state_next;
            if (take && state_reg != state_next) byteCnt_reg <= 4'h0;
            else if (take) byteCnt_reg <= byteCnt_reg + 4'h1;
            if (state_reg == S_WRITE) byteCnt_reg <= 4'h0;
            if (needByte && !byteValid && readerOvf) ovfFlag_reg <= 1'b1;
            else if (busWr && avsAddress == `ERL_OFS_CMD && avsWriteData[`ERL_CMD_OVF])
               ovfFlag_reg <= 1'b0;
            if (take && state_reg == S_SFLAG) strapValid_reg <= isValid;
            // soft straps, first byte lands in the low lane
            if (take && state_reg == S_STRAP && strapValid_reg) begin
               case (byteCnt_reg[1:0])
                  2'h0:    strapValue[7:0]   <= byteData;
                  2'h1:    strapValue[15:8]  <= byteData;
                  2'h2:    strapValue[23:16] <= byteData;
                  default: strapValue[31:24] <= byteData;
               endcase
            end
            // phy resync once straps are final
            if ((take && state_reg == S_CHECK && !isValid) ||
                (take && state_reg == S_STRAP && byteCnt_reg == `ERL_STRAP_BYTES - 4'h1))
               phyResync <= 1'b1;
            if (take && state_reg == S_BCNT) burstCnt_reg <= byteData;
            if (take && state_reg == S_HADDR) dwAddr_reg <= byteData;
            if (take && state_reg == S_HCNT) begin
               dwCnt_reg <= byteData;
               if (byteData == 8'h00) burstCnt_reg <= burstCnt_reg - 8'h01;
            end
            if (take && state_reg == S_DATA)
               assemble_reg <= {assemble_reg[23:0], byteData};
            if (state_reg == S_WRITE && wrClear) begin
               regWrEn     <= 1'b1;
               regWrAddr   <= {dwAddr_reg, 2'b00};
               regWrData   <= assemble_reg;
               wrCount_reg <= wrCount_reg + 32'h00000001;
               dwAddr_reg  <= dwAddr_reg + 8'h01;
               dwCnt_reg   <= dwCnt_reg - 8'h01;
               if (dwCnt_reg == 8'h01) burstCnt_reg <= burstCnt_reg - 8'h01;
            end
            // busy drops once the last write or resync pulse has gone out
            if (state_reg == S_WAIT) busy_reg <= 1'b0;
         end
      end
   end

   // avalon slave: one wait cycle, answer on the second edge
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ack_reg     <= 1'b0;
         avsReadData <= 32'h00000000;
      end else begin
         ack_reg <= (avsRead | avsWrite) & ~ack_reg;
         if (avsRead && !ack_reg) begin
            case (avsAddress)
               `ERL_OFS_CMD: begin
                  avsReadData                 <= 32'h00000000;
                  avsReadData[`ERL_CMD_BUSY]  <= busy_reg;
                  avsReadData[`ERL_CMD_OVF]   <= ovfFlag_reg;
               end
               `ERL_OFS_HWCFG: begin
                  avsReadData                 <= 32'h00000000;
                  avsReadData[`ERL_HW_READY]  <= ~busy_reg;
               end
               `ERL_OFS_STRAP: avsReadData <= strapValue;
               `ERL_OFS_WRCNT: avsReadData <= wrCount_reg;
               default:        avsReadData <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // erl_loader

// file: tb/erl_eeprom_model.sv
// behavioural eeprom answering the loader byte port
// assumes a request is held with its address until acknowledged
`timescale 1ns/1ns
module erl_eeprom_model (
   // clock
   input  wire        clk,
   // byte port
   input  wire        eeReq,
   input  wire [15:0] eeAddr,
   output reg         eeAck,
   output reg  [7:0]  eeData,
   // answer delay in cycles
   input  wire [3:0]  latency
);
   reg [7:0] mem [0:255];
   reg [3:0] waitCnt;
   initial begin
      eeAck = 1'b0;
      eeData = 8'h00;
      waitCnt = 4'h0;
   end
   always @(posedge clk) begin
      eeAck  <= 1'b0;
      // line keeps toggling outside an answer
      eeData <= ~eeData;
      if (eeReq && !eeAck) begin
         if (waitCnt == latency) begin
            eeAck   <= 1'b1;
            eeData  <= mem[eeAddr[7:0]];
            waitCnt <= 4'h0;
         end else begin
            waitCnt <= waitCnt + 4'h1;
         end
      end
   end
endmodule // erl_eeprom_model

// file: tb/erl_loader_props.sv
// port assertions for erl_loader
// assumes one clock and an active high asynchronous reset
`timescale 1ns/1ns
`include "erl_map.vh"
module erl_loader_props (
   // clock and reset
   input wire        clk,
   input wire        reset,
   // register bus
   input wire [3:0]  avsAddress,
   input wire        avsWrite,
   input wire [31:0] avsWriteData,
   input wire        avsWaitRequest,
   // loader side
   input wire        digitalReset,
   input wire [1:0]  eepromSizeStrap,
   input wire        eeReq,
   input wire [15:0] eeAddr,
   input wire        switchPortBusy,
   input wire        phyMgmtBusy,
   input wire        regWrEn,
   input wire [31:0] strapValue,
   input wire        phyResync,
   input wire        loaderBusy,
   input wire        deviceReady
);
   wire [15:0] eeLimit = (eepromSizeStrap == 2'h0) ? `ERL_LIMIT_0 :
                         (eepromSizeStrap == 2'h1) ? `ERL_LIMIT_1 :
                         (eepromSizeStrap == 2'h2) ? `ERL_LIMIT_2 : `ERL_LIMIT_3;
   wire reloadTaken = avsWrite & ~avsWaitRequest & (avsAddress == `ERL_OFS_CMD)
                      & avsWriteData[`ERL_CMD_RELOAD];
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   ready_busy_a: assert property (deviceReady == !loaderBusy)
      else $error("ready not inverse of busy");
   restart_busy_a: assert property ((digitalReset || (reloadTaken && !loaderBusy))
      |-> ##[1:2] loaderBusy) else $error("restart did not set busy");
   write_clear_a: assert property (regWrEn |-> !$past(switchPortBusy) && !$past(phyMgmtBusy))
      else $error("write while an interface was busy");
   write_space_a: assert property (regWrEn |=> !regWrEn [*4])
      else $error("writes closer than one dword");
   write_loading_a: assert property (regWrEn |-> loaderBusy)
      else $error("write outside loading");
   read_limit_a: assert property (eeReq |-> eeAddr <= eeLimit)
      else $error("eeprom read beyond limit");
   resync_pulse_a: assert property (phyResync |=> !phyResync)
      else $error("resync longer than one cycle");
   idle_quiet_a: assert property (!loaderBusy |-> !regWrEn && !phyResync)
      else $error("activity while idle");
   strap_stable_a: assert property ((!loaderBusy && !digitalReset && !avsWrite)
      |=> $stable(strapValue)) else $error("straps changed while idle");
   cover property (regWrEn);
   cover property (phyResync);
   cover property (eeReq && eeAddr == eeLimit);
endmodule // erl_loader_props
bind erl_loader erl_loader_props CHK (.clk(clk), .reset(reset), .avsAddress(avsAddress),
   .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsWaitRequest(avsWaitRequest),
   .digitalReset(digitalReset), .eepromSizeStrap(eepromSizeStrap), .eeReq(eeReq),
   .eeAddr(eeAddr), .switchPortBusy(switchPortBusy), .phyMgmtBusy(phyMgmtBusy),
   .regWrEn(regWrEn), .strapValue(strapValue), .phyResync(phyResync),
   .loaderBusy(loaderBusy), .deviceReady(deviceReady));

// file: tb/erl_loader_tb.sv
// self-checking bench for erl_loader with an eeprom model
// assumes the 25 mhz clock and avalon slave answering after one cycle
`timescale 1ns/1ns
`include "erl_map.vh"
module erl_loader_tb;
   reg         clk, reset, avsRead, avsWrite, digitalReset, switchPortBusy, phyMgmtBusy;
   reg  [3:0]  avsAddress, latency;
   reg  [31:0] avsWriteData, strapIn, rdat;
   reg  [1:0]  eepromSizeStrap;
   reg  [15:0] maxAddr;
   reg  [41:0] writes [$];
   reg  [41:0] expW [0:2];
   wire [31:0] avsReadData, regWrData, strapValue;
   wire [15:0] eeAddr;
   wire [9:0]  regWrAddr;
   wire [7:0]  eeData;
   wire        avsWaitRequest, eeReq, eeAck, regWrEn, phyResync, loaderBusy, deviceReady;
   integer     mismatches, total_checks, cycles, resyncs, i;

   erl_loader DUT (.clk(clk), .reset(reset), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest), .digitalReset(digitalReset), .strapIn(strapIn),
      .eepromSizeStrap(eepromSizeStrap), .eeReq(eeReq), .eeAddr(eeAddr), .eeAck(eeAck),
      .eeData(eeData), .switchPortBusy(switchPortBusy), .phyMgmtBusy(phyMgmtBusy),
      .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData),
      .strapValue(strapValue), .phyResync(phyResync), .loaderBusy(loaderBusy),
      .deviceReady(deviceReady));
   erl_eeprom_model EE (.clk(clk), .eeReq(eeReq), .eeAddr(eeAddr), .eeAck(eeAck),
      .eeData(eeData), .latency(latency));

   always #20 clk = ~clk;

   task complete_run;
      begin
         $display("checks %0d, mismatches %0d", total_checks, mismatches);
         if (mismatches == 0 && total_checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask

   task check_val(input string name, input [41:0] seen, input [41:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("unexpected %0s: expected %h, seen %h", name, exp, seen);
         end
      end
   endtask

   // one avalon access, held until waitrequest is seen low
   task av_xfer(input [3:0] a, input wr, input [31:0] d);
      begin
         @(posedge clk);
         avsAddress   <= a;
         avsWrite     <= wr;
         avsRead      <= ~wr;
         avsWriteData <= d;
         @(posedge clk);
         while (avsWaitRequest !== 1'b0) @(posedge clk);
         rdat = avsReadData;
         avsWrite <= 1'b0;
         avsRead  <= 1'b0;
      end
   endtask

   task wait_idle;
      begin
         repeat (3) @(posedge clk);
         while (loaderBusy !== 1'b0) @(posedge clk);
      end
   endtask

   always @(posedge clk) begin
      cycles = cycles + 1;
      if (regWrEn === 1'b1) writes.push_back({regWrAddr, regWrData});
      if (phyResync === 1'b1) resyncs = resyncs + 1;
      if (eeReq === 1'b1 && eeAddr > maxAddr) maxAddr = eeAddr;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         complete_run;
      end
   end

   initial begin
      clk = 1'b0;
      reset = 1'b1;
      {avsRead, avsWrite, digitalReset, phyMgmtBusy} = 4'h0;
      switchPortBusy = 1'b1;
      avsAddress = 4'h0;
      avsWriteData = 32'h0;
      strapIn = 32'h5a3c_96e1;
      eepromSizeStrap = 2'h0;
      latency = 4'h3;
      maxAddr = 16'h0;
      {mismatches, total_checks, cycles, resyncs} = 0;
      for (i = 0; i < 256; i = i + 1) EE.mem[i] = 8'h00;
      EE.mem[0] = 8'ha5;
      EE.mem[7] = 8'ha5;
      for (i = 8; i < 12; i = i + 1) EE.mem[i] = i - 7;
      EE.mem[12] = 8'ha5;
      EE.mem[13] = 8'h02;
      EE.mem[14] = 8'h10;
      EE.mem[15] = 8'h01;
      for (i = 16; i < 20; i = i + 1) EE.mem[i] = 8'h11 + i - 16;
      EE.mem[20] = 8'h20;
      EE.mem[21] = 8'h02;
      for (i = 22; i < 30; i = i + 1) EE.mem[i] = 8'h21 + i - 22;
      expW[0] = {10'h040, 32'h11121314};
      expW[1] = {10'h080, 32'h21222324};
      expW[2] = {10'h084, 32'h25262728};
      repeat (19) @(posedge clk);
      check_val("busy in reset", loaderBusy, 1);
      check_val("ready in reset", deviceReady, 0);
      @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      check_val("sampled straps", strapValue, strapIn);
      repeat (300) @(posedge clk);
      check_val("writes while switch_port_busy", writes.size(), 0);
      switchPortBusy <= 1'b0;
      phyMgmtBusy <= 1'b1;
      repeat (30) @(posedge clk);
      check_val("writes while phy busy", writes.size(), 0);
      phyMgmtBusy <= 1'b0;
      wait_idle;
      check_val("write count", writes.size(), 3);
      for (i = 0; i < 3; i = i + 1) check_val("burst write", writes[i], expW[i]);
      av_xfer(`ERL_OFS_CMD, 1'b0, 32'h0);
      check_val("busy bit", rdat[`ERL_CMD_BUSY], 0);
      av_xfer(`ERL_OFS_HWCFG, 1'b0, 32'h0);
      check_val("ready bit", rdat[`ERL_HW_READY], 1);
      av_xfer(`ERL_OFS_STRAP, 1'b1, 32'h0);
      av_xfer(`ERL_OFS_STRAP, 1'b0, 32'h0);
      check_val("soft straps", rdat, 32'h04030201);
      av_xfer(`ERL_OFS_WRCNT, 1'b0, 32'h0);
      check_val("write counter", rdat, 3);
      av_xfer(4'h2, 1'b0, 32'h0);
      check_val("unmapped read", rdat, 0);
      check_val("resync pulses", resyncs, 1);
      // reload with straps and bursts marked invalid
      EE.mem[7] = 8'h00;
      EE.mem[12] = 8'h00;
      latency = 4'h0;
      av_xfer(`ERL_OFS_CMD, 1'b1, 32'h1);
      wait_idle;
      check_val("writes no bursts", writes.size(), 3);
      check_val("pin straps on reload", strapValue, strapIn);
      check_val("resync on reload", resyncs, 2);
      // digital reset with the image marked invalid
      EE.mem[0] = 8'h00;
      @(posedge clk);
      digitalReset <= 1'b1;
      @(posedge clk);
      digitalReset <= 1'b0;
      wait_idle;
      check_val("resync bad image", resyncs, 3);
      check_val("writes bad image", writes.size(), 3);
      // burst running past the smallest eeprom
      EE.mem[0] = 8'ha5;
      EE.mem[12] = 8'ha5;
      EE.mem[13] = 8'h01;
      EE.mem[15] = 8'h40;
      @(negedge clk) maxAddr = 16'h0;
      av_xfer(`ERL_OFS_CMD, 1'b1, 32'h1);
      wait_idle;
      check_val("writes to overflow", writes.size(), 31);
      check_val("last write", writes[30], {10'h0ac, 32'h0});
      check_val("highest read", maxAddr, 16'h007f);
      av_xfer(`ERL_OFS_CMD, 1'b0, 32'h0);
      check_val("overflow set", rdat[`ERL_CMD_OVF], 1);
      av_xfer(`ERL_OFS_CMD, 1'b1, 32'h400);
      av_xfer(`ERL_OFS_CMD, 1'b0, 32'h0);
      check_val("overflow cleared", rdat[`ERL_CMD_OVF], 0);
      complete_run;
   end
endmodule // erl_loader_tb
